// File: hdl/mor_pkg.sv
// Package with register map, field codes, limits and timing constants of the motor protection block.
package mor_pkg;
	// Register offsets on the serial link.
	localparam logic [15:0] ADDR_COOLING = 16'h0009;
	localparam logic [15:0] ADDR_LEVEL = 16'h000a;
	localparam logic [15:0] ADDR_TIME_CONST = 16'h000b;
	localparam logic [15:0] ADDR_REGEN_MODE = 16'h0315;
	localparam logic [15:0] ADDR_FREQ_LIMIT = 16'h0316;

	// Values after reset.
	localparam logic [15:0] RST_COOLING = 16'h0001;
	localparam logic [15:0] RST_LEVEL = 16'h00d2;
	localparam logic [15:0] RST_TIME_CONST = 16'h0032;
	localparam logic [15:0] RST_REGEN_MODE = 16'h0000;
	localparam logic [15:0] RST_FREQ_LIMIT = 16'h0032;

	// Legal ranges of the settings.
	localparam logic [15:0] COOLING_MIN = 16'h0001;
	localparam logic [15:0] COOLING_MAX = 16'h0002;
	localparam logic [15:0] LEVEL_MAX = 16'h0237;
	localparam logic [15:0] TIME_CONST_MIN = 16'h0005;
	localparam logic [15:0] TIME_CONST_MAX = 16'h02ee;
	localparam logic [15:0] REGEN_MODE_MAX = 16'h0004;
	localparam logic [15:0] FREQ_LIMIT_MAX = 16'h04b0;

	// Cooling types.
	localparam logic [15:0] COOL_SHAFT = 16'h0001;
	localparam logic [15:0] COOL_FAN = 16'h0002;

	// Derating corners in 0.1 Hz and factors in percent.
	localparam logic [15:0] DERATE_CORNER_LOW = 16'h0032;
	localparam logic [15:0] DERATE_CORNER_HIGH = 16'h0046;
	localparam logic [23:0] FACTOR_LOW = 24'h00004b;
	localparam logic [23:0] FACTOR_MID = 24'h000055;
	localparam logic [23:0] FACTOR_FULL = 24'h000064;

	// Anti-regenerative modes.
	typedef enum logic [2:0] {
		MODE_OFF = 3'b000,
		MODE_STRETCH = 3'b001,
		MODE_TORQUE = 3'b010,
		MODE_RESERVED = 3'b011,
		MODE_TORQUE_NOSTOP = 3'b100
	} mor_regen_mode_type;

	// Deceleration stretch factor and thermal trip ratio of 150 percent squared minus one, as 5/4.
	localparam logic [19:0] STRETCH_FACTOR = 20'h00003;
	localparam logic [55:0] TRIP_NUM = 56'h00000000000005;
	localparam int TRIP_SHIFT = 2;

	// Timing: the clock rate, the 1 ms control tick and the 0.1 minute thermal step.
	localparam int CLK_HZ = 20000000;
	localparam int MS_TICK_TIME_US = 1000;
	localparam int MS_TICK_CYCLES = (CLK_HZ / 1000000) * MS_TICK_TIME_US;
	localparam int THERM_STEP_TIME_MS = 6000;
	localparam int THERM_STEP_TICKS = THERM_STEP_TIME_MS;
endpackage

// File: hdl/mor_tick_div.sv
// Divider that turns enable pulses into one tick every CYCLES enables.
`timescale 1ns/1ps
module mor_tick_div #(
	parameter int CYCLES = 20000
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic en,
	output logic tick
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt_ff;
	logic tick_ff;
	wire at_last = (cnt_ff == LAST);

	// Count enables and pulse once on the last one, so the tick lasts exactly one clock.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= en & at_last;
			if (en) begin
				cnt_ff <= at_last ? '0 : cnt_ff + CW'(1);
			end
		end
	end

	assign tick = tick_ff;
endmodule // mor_tick_div

// File: hdl/mor_protect.sv
// Motor thermal overload model and anti-regenerative control with their setting registers.
//
// Overview of operation
// - Overload level zero disables thermal protection entirely.
// - Cooling type 1 means shaft-cooled, 2 means separate fan.
// - Shaft-cooled level derates to 75, 85, 100 percent at 5 and 7 Hz.
// - Fan-cooled motors use the set level unchanged at every frequency.
// - Level is held in 0.01 A steps, 0 to 567.
// - Current of 150 percent for one time constant raises overload.
// - Time constant is 0.5 to 75.0 minutes in tenths.
// - Overload raises the dedicated motor overload alarm code.
// - Heating accumulates once current exceeds the 100 percent level.
// - Time constant defaults to five minutes.
// - Mode 0 off, 1 stretch, 4 torque limit without stop, 0 to 4 legal.
// - Mode 1 triples deceleration time while DC link exceeds its limit.
// - Stretching acts only while decelerating.
// - Modes 2 and 4 raise frequency to hold braking torque near zero.
// - Raised frequency stays strictly below reference plus increment limit.
// - Increment limit is in 0.1 Hz steps, at most 1200.
// - Stop ramp cancels control after three decel times, in mode 2 only.
// - The increment cap wins over regulation.
`timescale 1ns/1ps
module mor_protect #(
	parameter int MS_CYCLES = mor_pkg::MS_TICK_CYCLES,
	parameter int THERM_TICKS = mor_pkg::THERM_STEP_TICKS,
	parameter logic [7:0] ALARM_CODE_OVERLOAD = 8'h0c
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [15:0] out_current,
	input wire logic [15:0] out_freq,
	input wire logic [15:0] ramp_freq,
	input wire logic [15:0] ref_freq,
	input wire logic [15:0] decel_time_ms,
	input wire logic decelerating,
	input wire logic run_cmd,
	input wire logic dc_over_limit,
	input wire logic regen_detect,
	input wire logic alarm_clear,
	output logic overload_alarm,
	output logic [7:0] alarm_code,
	output logic [19:0] decel_time_eff,
	output logic [15:0] freq_cmd,
	output logic regen_active,
	output logic regen_cancelled,
	output logic decel_stretch
);
	// A write outside its legal range is dropped so the settings never leave their range.
	function automatic logic in_rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction

	// Detection level after low-frequency derating for shaft-cooled motors.
	function automatic logic [15:0] derate(input logic [15:0] lvl, input logic [15:0] f, input logic [15:0] cool);
		logic [23:0] p;
		p = {8'h00, lvl} * mor_pkg::FACTOR_FULL;
		if (cool == mor_pkg::COOL_SHAFT && f < mor_pkg::DERATE_CORNER_LOW) begin
			p = {8'h00, lvl} * mor_pkg::FACTOR_LOW;
		end else if (cool == mor_pkg::COOL_SHAFT && f < mor_pkg::DERATE_CORNER_HIGH) begin
			p = {8'h00, lvl} * mor_pkg::FACTOR_MID;
		end
		return 16'(p / mor_pkg::FACTOR_FULL);
	endfunction

	logic [15:0] cooling_ff, level_ff, time_const_ff, mode_ff, freq_limit_ff;
	logic [15:0] reg_rdata_ff;
	logic reg_rvalid_ff;
	logic [55:0] heat_ff;
	logic alarm_ff;
	logic [7:0] alarm_code_ff;
	logic [19:0] decel_eff_ff;
	logic [19:0] elapsed_ff;
	logic cancel_ff;
	logic [15:0] ofs_ff;
	logic [15:0] freq_cmd_ff;
	logic active_ff;
	logic stretch_ff;
	logic ms_tick, therm_tick;

	// The 1 ms control tick, and the thermal step of 0.1 minute built from it.
	mor_tick_div #(.CYCLES(MS_CYCLES)) u_ms_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.en(1'b1),
		.tick(ms_tick)
	);
	mor_tick_div #(.CYCLES(THERM_TICKS)) u_therm_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.en(ms_tick),
		.tick(therm_tick)
	);

	// Register write decode with range checks.
	wire wr_cool = reg_wr && reg_addr == mor_pkg::ADDR_COOLING
		&& in_rng(reg_wdata, mor_pkg::COOLING_MIN, mor_pkg::COOLING_MAX);
	wire wr_level = reg_wr && reg_addr == mor_pkg::ADDR_LEVEL
		&& in_rng(reg_wdata, 16'h0000, mor_pkg::LEVEL_MAX);
	wire wr_tc = reg_wr && reg_addr == mor_pkg::ADDR_TIME_CONST
		&& in_rng(reg_wdata, mor_pkg::TIME_CONST_MIN, mor_pkg::TIME_CONST_MAX);
	wire wr_mode = reg_wr && reg_addr == mor_pkg::ADDR_REGEN_MODE
		&& in_rng(reg_wdata, 16'h0000, mor_pkg::REGEN_MODE_MAX);
	wire wr_limit = reg_wr && reg_addr == mor_pkg::ADDR_FREQ_LIMIT
		&& in_rng(reg_wdata, 16'h0000, mor_pkg::FREQ_LIMIT_MAX);

	// Read mux; an unmapped address reads as zero.
	wire [15:0] nxt_rdata = (reg_addr == mor_pkg::ADDR_COOLING) ? cooling_ff :
		(reg_addr == mor_pkg::ADDR_LEVEL) ? level_ff :
		(reg_addr == mor_pkg::ADDR_TIME_CONST) ? time_const_ff :
		(reg_addr == mor_pkg::ADDR_REGEN_MODE) ? mode_ff :
		(reg_addr == mor_pkg::ADDR_FREQ_LIMIT) ? freq_limit_ff : 16'h0000;

	// Setting registers; the time constant comes out of reset at five minutes.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cooling_ff <= mor_pkg::RST_COOLING;
			level_ff <= mor_pkg::RST_LEVEL;
			time_const_ff <= mor_pkg::RST_TIME_CONST;
			mode_ff <= mor_pkg::RST_REGEN_MODE;
			freq_limit_ff <= mor_pkg::RST_FREQ_LIMIT;
			reg_rdata_ff <= 16'h0000;
			reg_rvalid_ff <= 1'b0;
		end else begin
			if (wr_cool) cooling_ff <= reg_wdata;
			if (wr_level) level_ff <= reg_wdata;
			if (wr_tc) time_const_ff <= reg_wdata;
			if (wr_mode) mode_ff <= reg_wdata;
			if (wr_limit) freq_limit_ff <= reg_wdata;
			reg_rvalid_ff <= reg_rd;
			if (reg_rd) reg_rdata_ff <= nxt_rdata;
		end
	end

	// Thermal model: squared current against the squared derated level.
	// The heat store is 56 bits wide so a full-scale current at the longest time constant cannot wrap it.
	wire prot_on = (level_ff != 16'h0000);
	wire [15:0] det_level = derate(level_ff, out_freq, cooling_ff);
	wire [31:0] cur_sq = out_current * out_current;
	wire [31:0] lvl_sq = det_level * det_level;
	wire heating = cur_sq > lvl_sq;
	wire [55:0] heat_up = heat_ff + {24'h000000, cur_sq - lvl_sq};
	wire [55:0] cool_dn = {24'h000000, lvl_sq - cur_sq};
	wire [55:0] trip_level = ({24'h000000, lvl_sq} * {40'h0, time_const_ff} * mor_pkg::TRIP_NUM)
		>> mor_pkg::TRIP_SHIFT;
	wire [55:0] nxt_heat = !prot_on ? 56'h0 :
		!therm_tick ? heat_ff :
		heating ? heat_up :
		(heat_ff > cool_dn) ? heat_ff - cool_dn : 56'h0;
	wire trip = prot_on && heat_ff >= trip_level && trip_level != 56'h0;
	wire nxt_alarm = prot_on && (trip || (alarm_ff && !alarm_clear));

	// The alarm latches until cleared or the level is set to zero; a trip in the clearing cycle keeps it set.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			heat_ff <= 56'h0;
			alarm_ff <= 1'b0;
			alarm_code_ff <= 8'h00;
		end else begin
			heat_ff <= nxt_heat;
			alarm_ff <= nxt_alarm;
			alarm_code_ff <= nxt_alarm ? ALARM_CODE_OVERLOAD : 8'h00;
		end
	end

	// Mode decode; mode 3 is legal to write but decodes to nothing, so it leaves control disabled.
	wire [2:0] mode_code = mode_ff[2:0];
	wire mode_stretch = (mode_code == mor_pkg::MODE_STRETCH);
	wire mode_torque = (mode_code == mor_pkg::MODE_TORQUE) || (mode_code == mor_pkg::MODE_TORQUE_NOSTOP);
	wire stop_allowed = (mode_code == mor_pkg::MODE_TORQUE);

	// Deceleration stretch in mode 1, only while decelerating.
	wire nxt_stretch = mode_stretch && decelerating && dc_over_limit;
	wire [19:0] nxt_decel_eff = nxt_stretch ? {4'h0, decel_time_ms} * mor_pkg::STRETCH_FACTOR
		: {4'h0, decel_time_ms};

	// Forced stop: elapsed stop-ramp time compared with three deceleration times.
	wire stop_ramp = decelerating && !run_cmd;
	wire [19:0] stop_limit = {4'h0, decel_time_ms} * mor_pkg::STRETCH_FACTOR;
	wire nxt_cancel = stop_ramp && (cancel_ff || (stop_allowed && elapsed_ff >= stop_limit));
	wire [19:0] nxt_elapsed = !stop_ramp ? 20'h0 :
		(ms_tick && elapsed_ff != 20'hfffff) ? elapsed_ff + 20'h1 : elapsed_ff;

	// Torque-limit regulation: offset grows while regenerating, capped below reference plus limit.
	// One step of 0.1 Hz per millisecond keeps the command smooth at the cost of a slower reaction.
	wire nxt_active = mode_torque && !nxt_cancel;
	wire [16:0] cap = {1'b0, ref_freq} + {1'b0, freq_limit_ff};
	wire [16:0] raised = {1'b0, ramp_freq} + {1'b0, ofs_ff};
	wire room = (raised + 17'h1) < cap;
	wire [15:0] nxt_ofs = !nxt_active ? 16'h0 :
		!ms_tick ? ofs_ff :
		(regen_detect && room) ? ofs_ff + 16'h1 :
		(!regen_detect && ofs_ff != 16'h0) ? ofs_ff - 16'h1 : ofs_ff;
	wire [16:0] cap_m1 = cap - 17'h1;
	wire [15:0] nxt_freq = (ofs_ff == 16'h0) ? ramp_freq :
		(raised < cap) ? raised[15:0] :
		(cap > {1'b0, ramp_freq}) ? cap_m1[15:0] : ramp_freq;

	// Anti-regenerative state and outputs.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			decel_eff_ff <= 20'h0;
			stretch_ff <= 1'b0;
			elapsed_ff <= 20'h0;
			cancel_ff <= 1'b0;
			active_ff <= 1'b0;
			ofs_ff <= 16'h0;
			freq_cmd_ff <= 16'h0;
		end else begin
			decel_eff_ff <= nxt_decel_eff;
			stretch_ff <= nxt_stretch;
			elapsed_ff <= nxt_elapsed;
			cancel_ff <= nxt_cancel;
			active_ff <= nxt_active;
			ofs_ff <= nxt_ofs;
			freq_cmd_ff <= nxt_freq;
		end
	end

	assign reg_rdata = reg_rdata_ff;
	assign reg_rvalid = reg_rvalid_ff;
	assign overload_alarm = alarm_ff;
	assign alarm_code = alarm_code_ff;
	assign decel_time_eff = decel_eff_ff;
	assign freq_cmd = freq_cmd_ff;
	assign regen_active = active_ff;
	assign regen_cancelled = cancel_ff;
	assign decel_stretch = stretch_ff;

	// Checks on the behaviour above.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_stop_ramp_expired;
		stop_ramp && stop_allowed && elapsed_ff >= stop_limit;
	endsequence

	chk_level_zero_off: assert property (level_ff == 16'h0 |=> !alarm_ff && heat_ff == 56'h0)
		else $error("Alarm or heat present with protection disabled.");
	chk_cool_bad_drop: assert property (reg_wr && reg_addr == mor_pkg::ADDR_COOLING
		&& reg_wdata != 16'h1 && reg_wdata != 16'h2 |=> $stable(cooling_ff))
		else $error("Illegal cooling type was stored.");
	chk_derate_low: assert property (cooling_ff == 16'h1 && out_freq < 16'h32
		|-> det_level == 16'((level_ff * 24'd3) / 24'd4))
		else $error("Low-frequency derating is not 75 percent.");
	chk_fan_constant: assert property (cooling_ff == 16'h2 |-> det_level == level_ff)
		else $error("Fan-cooled level was derated.");
	chk_level_range: assert property (level_ff <= 16'h0237)
		else $error("Overload level out of range.");
	chk_tc_range: assert property (time_const_ff >= 16'h5 && time_const_ff <= 16'h2ee)
		else $error("Time constant out of range.");
	chk_alarm_code: assert property (alarm_ff |-> alarm_code_ff == ALARM_CODE_OVERLOAD)
		else $error("Overload alarm without its code.");
	chk_trip_sets: assert property (trip |=> alarm_ff)
		else $error("Trip did not raise the alarm.");
	chk_heat_rise: assert property (prot_on && therm_tick && heating && !heat_up[55]
		|=> heat_ff > $past(heat_ff))
		else $error("Heat did not rise above the continuous level.");
	chk_stretch_x3: assert property (mode_stretch && decelerating && dc_over_limit
		|=> decel_eff_ff == 20'($past(decel_time_ms)) * 20'h3)
		else $error("Deceleration time not tripled.");
	chk_no_stretch: assert property (!decelerating |=> decel_eff_ff == 20'($past(decel_time_ms)))
		else $error("Deceleration time changed outside deceleration.");
	chk_freq_cap: assert property (ofs_ff != 16'h0 |=> freq_cmd_ff == $past(ramp_freq)
		|| {1'b0, freq_cmd_ff} < $past(cap))
		else $error("Raised frequency reached the cap.");
	chk_cancel_ramp: assert property (s_stop_ramp_expired |=> cancel_ff && !active_ff)
		else $error("Forced stop did not cancel control.");
	chk_mode4_nostop: assert property (mode_code == 3'h4 && !cancel_ff |=> !cancel_ff)
		else $error("Mode 4 cancelled control.");

	// Refused writes never land, so every setting stays inside its legal range; also mid derating and alarm hold and code.
	chk_cool_range: assert property (cooling_ff == 16'h1 || cooling_ff == 16'h2)
		else $error("Cooling type out of range.");
	chk_mode_range: assert property (mode_ff <= 16'h0004)
		else $error("Regeneration mode out of range.");
	chk_limit_range: assert property (freq_limit_ff <= 16'h04b0)
		else $error("Increment limit out of range.");
	chk_derate_mid: assert property (cooling_ff == 16'h1 && out_freq >= 16'h32 && out_freq < 16'h46
		|-> det_level == 16'((level_ff * 24'd17) / 24'd20))
		else $error("Mid-frequency derating is not 85 percent.");
	chk_alarm_hold: assert property (alarm_ff && prot_on && !alarm_clear |=> alarm_ff)
		else $error("Overload alarm dropped without a clear.");
	chk_alarm_code_off: assert property (!alarm_ff |-> alarm_code_ff == 8'h00)
		else $error("Alarm code shown without an alarm.");

	// Mode decode, stretching, the stop ramp and the increment cap.
	chk_mode_off: assert property (mode_code == 3'h0 |=> !active_ff && !stretch_ff)
		else $error("Disabled mode left control active.");
	chk_torque_only: assert property (!mode_torque |=> !active_ff && ofs_ff == 16'h0)
		else $error("Regulation active outside the torque-limit modes.");
	chk_stretch_decel: assert property (!decelerating |=> !stretch_ff)
		else $error("Stretch flag raised outside deceleration.");
	chk_cancel_clear: assert property (!stop_ramp |=> !cancel_ff)
		else $error("Cancellation held outside the stop ramp.");
	chk_cap_first: assert property (nxt_active && ms_tick && !room |=> ofs_ff <= $past(ofs_ff))
		else $error("Offset grew although the cap was reached.");
endmodule // mor_protect

// File: verif/mor_stage_model.sv
// Behavioural model of the inverter power stage and motor that face the protection block.
`timescale 1ns/1ps
module mor_stage_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [15:0] freq_cmd,
	input wire logic [15:0] rotor_freq,
	input wire logic [15:0] load_current,
	output logic [15:0] out_current,
	output logic [15:0] out_freq,
	output logic regen_detect,
	output logic dc_over_limit
);
	// The motor brakes the drive whenever its rotor runs ahead of the applied frequency.
	assign regen_detect = rotor_freq > freq_cmd;
	assign out_freq = freq_cmd;
	// The link capacitor charges a cycle after braking starts, so the over-limit flag lags it.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dc_over_limit <= 1'b0;
			out_current <= 16'h0000;
		end else begin
			dc_over_limit <= regen_detect;
			out_current <= load_current;
		end
	end
endmodule // mor_stage_model

// File: verif/mor_protect_tb_top.sv
// Self-checking testbench of the motor protection block with its power stage model.
`timescale 1ns/1ps
module mor_protect_tb_top;
	logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid, decelerating = 1'b0;
	logic run_cmd = 1'b1, dc_over_limit, regen_detect, overload_alarm, regen_active, regen_cancelled, decel_stretch;
	logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, out_current, out_freq, freq_cmd;
	logic [15:0] ramp_freq = 16'h0064, ref_freq = 16'h0064, decel_time_ms = 16'h0002, rotor = 16'h0000, load = 16'h0000;
	logic [7:0] alarm_code;
	logic [19:0] decel_time_eff;
	int errors = 0, n_compared = 0, cyc = 0;
	mor_protect #(.MS_CYCLES(4), .THERM_TICKS(2)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.out_current(out_current), .out_freq(out_freq), .ramp_freq(ramp_freq), .ref_freq(ref_freq),
		.decel_time_ms(decel_time_ms), .decelerating(decelerating), .run_cmd(run_cmd), .dc_over_limit(dc_over_limit),
		.regen_detect(regen_detect), .alarm_clear(1'b0), .overload_alarm(overload_alarm), .alarm_code(alarm_code),
		.decel_time_eff(decel_time_eff), .freq_cmd(freq_cmd), .regen_active(regen_active),
		.regen_cancelled(regen_cancelled), .decel_stretch(decel_stretch));
	mor_stage_model stage (.clk_sys(clk_sys), .rst_n(rst_n), .freq_cmd(freq_cmd), .rotor_freq(rotor),
		.load_current(load), .out_current(out_current), .out_freq(out_freq), .regen_detect(regen_detect),
		.dc_over_limit(dc_over_limit));
	// The clock toggles every half period of 25 ns.
	initial begin
		forever #25 clk_sys = ~clk_sys;
	end
	// A hung wait is cut short well beyond the few hundred cycles the run needs.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 4000) begin
			errors++;
			final_report();
		end
	end
	task automatic final_report();
		if (errors == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Inputs move 5 ns after the rising edge so the design samples settled values.
	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys);
		#5;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		cycles(1);
		reg_wr = 1'b0;
		cycles(1);
	endtask
	// The answer stands for the single cycle after the strobe edge, so it is judged right there.
	task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		cycles(1);
		reg_rd = 1'b0;
		chk("rvalid", 20'h1, {19'h0, reg_rvalid});
		chk("rdata", {4'h0, exp}, {4'h0, reg_rdata});
		cycles(1);
	endtask
	task automatic t_reset();
		rdc(mor_pkg::ADDR_COOLING, 16'h0001);
		rdc(mor_pkg::ADDR_TIME_CONST, 16'h0032);
		rdc(mor_pkg::ADDR_REGEN_MODE, 16'h0000);
		rdc(mor_pkg::ADDR_FREQ_LIMIT, 16'h0032);
		rdc(16'h0100, 16'h0000);
	endtask
	// Each row is address, value written, value read back; refused values leave the old one.
	task automatic t_range();
		logic [47:0] tbl [10] = '{{mor_pkg::ADDR_LEVEL, 16'h0238, 16'h00d2}, {mor_pkg::ADDR_LEVEL, 16'h0237, 16'h0237},
			{mor_pkg::ADDR_TIME_CONST, 16'h0004, 16'h0032}, {mor_pkg::ADDR_TIME_CONST, 16'h02ee, 16'h02ee},
			{mor_pkg::ADDR_TIME_CONST, 16'h02ef, 16'h02ee}, {mor_pkg::ADDR_REGEN_MODE, 16'h0005, 16'h0000},
			{mor_pkg::ADDR_REGEN_MODE, 16'h0004, 16'h0004}, {mor_pkg::ADDR_FREQ_LIMIT, 16'h04b1, 16'h0032},
			{mor_pkg::ADDR_FREQ_LIMIT, 16'h04b0, 16'h04b0}, {mor_pkg::ADDR_COOLING, 16'h0003, 16'h0001}};
		for (int i = 0; i < 10; i++) begin
			wr(tbl[i][47:32], tbl[i][31:16]);
			rdc(tbl[i][47:32], tbl[i][15:0]);
		end
	endtask
	task automatic t_stretch();
		wr(mor_pkg::ADDR_REGEN_MODE, 16'h0001);
		decel_time_ms = 16'd1000;
		rotor = 16'd200;
		decelerating = 1'b1;
		cycles(3);
		chk("stretch", 20'h1, {19'h0, decel_stretch});
		chk("decel_eff", 20'd3000, decel_time_eff);
		decelerating = 1'b0;
		cycles(2);
		chk("stretch_acc", 20'h0, {19'h0, decel_stretch});
		chk("decel_eff_acc", 20'd1000, decel_time_eff);
	endtask
	// Braking pushes the command up, but the cap of 0.5 Hz above reference stops it at 10.4 Hz.
	task automatic t_regen();
		wr(mor_pkg::ADDR_FREQ_LIMIT, 16'h0005);
		wr(mor_pkg::ADDR_REGEN_MODE, 16'h0004);
		cycles(100);
		chk("regen_active", 20'h1, {19'h0, regen_active});
		chk("freq_capped", 20'd104, {4'h0, freq_cmd});
		rotor = 16'd0;
		cycles(40);
		chk("freq_back", 20'd100, {4'h0, freq_cmd});
	endtask
	// A stop ramp of 2 ms is cancelled after 6 ms of ticks only where forced stop is kept.
	task automatic t_cancel(input logic [15:0] mode, input logic exp);
		wr(mor_pkg::ADDR_REGEN_MODE, mode);
		decel_time_ms = 16'd2;
		rotor = 16'd200;
		run_cmd = 1'b0;
		decelerating = 1'b1;
		cycles(16);
		chk("cancel_early", 20'h0, {19'h0, regen_cancelled});
		cycles(40);
		chk("cancel", {19'h0, exp}, {19'h0, regen_cancelled});
		chk("cancel_active", {19'h0, !exp}, {19'h0, regen_active});
		run_cmd = 1'b1;
		decelerating = 1'b0;
		rotor = 16'd0;
		cycles(2);
	endtask
	// At 3 Hz a fan-cooled motor keeps its full level, so 150 percent takes five steps to trip.
	task automatic t_thermal();
		int n;
		wr(mor_pkg::ADDR_REGEN_MODE, 16'h0000);
		wr(mor_pkg::ADDR_COOLING, 16'h0002);
		wr(mor_pkg::ADDR_LEVEL, 16'h0064);
		wr(mor_pkg::ADDR_TIME_CONST, 16'h0005);
		ramp_freq = 16'd30;
		load = 16'd150;
		cycles(24);
		chk("alarm_early", 20'h0, {19'h0, overload_alarm});
		n = 0;
		while (overload_alarm !== 1'b1 && n < 60) begin
			cycles(1);
			n++;
		end
		chk("alarm", 20'h1, {19'h0, overload_alarm});
		chk("alarm_code", 20'h0000c, {12'h0, alarm_code});
		wr(mor_pkg::ADDR_LEVEL, 16'h0000);
		cycles(3);
		chk("alarm_off", 20'h0, {19'h0, overload_alarm});
	endtask
	// At 6 Hz a shaft-cooled level of 1.00 A derates to 0.85 A, so 1.50 A trips in three steps instead of five.
	task automatic t_derate();
		ramp_freq = 16'd60;
		wr(mor_pkg::ADDR_COOLING, 16'h0001);
		wr(mor_pkg::ADDR_LEVEL, 16'h0064);
		cycles(14);
		chk("derate_early", 20'h0, {19'h0, overload_alarm});
		cycles(14);
		chk("derate_alarm", 20'h1, {19'h0, overload_alarm});
	endtask
	initial begin
		cycles(4);
		rst_n = 1'b1;
		cycles(1);
		t_reset();
		t_range();
		t_stretch();
		t_regen();
		t_cancel(16'h0002, 1'b1);
		t_cancel(16'h0004, 1'b0);
		t_thermal();
		t_derate();
		final_report();
	end
endmodule // mor_protect_tb_top
